/* File: src/gas_pkg.sv */
// Constants shared by the address and status register bank
package gas_pkg;
	// Host register offsets
	localparam logic [1:0] OFS_ACCESSORY = 2'h0;
	localparam logic [1:0] OFS_ADDRESS = 2'h1;
	localparam logic [1:0] OFS_DATA = 2'h2;
	// Accessory selector in write bits 7..4
	localparam logic [3:0] ACC_SEL_POLL_DMA = 4'he;
	localparam int ACC_SEL_MSB = 7;
	localparam int ACC_SEL_LSB = 4;
	localparam int ACC_SHORT_DELAY_BIT = 3;
	localparam int ACC_POLL_CFG_BIT = 2;
	localparam int ACC_DMA_EN_BIT = 0;
	// Primary address register fields
	localparam int PRIM_DUAL_BIT = 7;
	localparam int PRIM_NO_LISTEN_BIT = 6;
	localparam int PRIM_NO_TALK_BIT = 5;
	localparam int PRIM_FIELD_MSB = 4;
	// Status register fields
	localparam int ST_REMOTE_BIT = 7;
	localparam int ST_LOCKOUT_BIT = 6;
	localparam int ST_ATN_BIT = 5;
	localparam int ST_LISTEN_SEEN_BIT = 4;
	localparam int ST_TPAS_BIT = 3;
	localparam int ST_LA_BIT = 2;
	localparam int ST_TA_BIT = 1;
	localparam int ST_ULPA_BIT = 0;
	// Bus command codes
	localparam logic [6:0] TALK_BASE = 7'h40;
	localparam logic [6:0] LISTEN_BASE = 7'h20;
	localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
	localparam logic [1:0] GROUP_TALK = 2'h2;
	localparam logic [1:0] GROUP_SECONDARY = 2'h3;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Settling delay
	localparam int CLK_PERIOD_NS = 40;
	localparam int SHORT_SETTLE_NS = 350;
	localparam int NORMAL_SETTLE_NS = 2000;
	localparam int SHORT_SETTLE_CYC = (SHORT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NORMAL_SETTLE_CYC = (NORMAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 6;
	typedef enum logic [1:0] {
		GAS_SETTLE_IDLE = 2'b01,
		GAS_SETTLE_RUN = 2'b10
	} gas_settle_t;
endpackage

/* File: src/gas_regs.sv */
// Address and status register bank of the bus talker/listener interface
// Summary of operation
// - The poll/DMA accessory register is written at the shared accessory offset with bits 7..4 equal to 1110, bit 1 ignored.
// - With dual addressing enabled the device answers to two consecutive primary addresses.
// - While listener disable is set the listener stays idle despite its listen address or listen-only.
// - While talker disable is set the talker stays idle despite its talk address or talk-only.
// - The five-bit address plus 40 hex is the talk address and plus 20 hex the listen address.
// - Status bits 7 and 6 show remote and lockout of the remote/local function.
// - Status bit 5 reads 1 while the active-low attention line is asserted.
// - Status bit 4 sets on the own listen address and clears on reset or another accepted primary command.
// - Status bit 0 holds the low bit of the last received own talk or listen address and channel reset clears it.
`timescale 1ns/10ps
module gas_regs (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Host register port
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Bus pins
	input wire logic atn_n_in,
	input wire logic ifc_n_in,
	// Command acceptance from the handshake logic
	input wire logic cmd_accept_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic listen_only_in,
	input wire logic talk_only_in,
	input wire logic chan_reset_in,
	input wire logic rl_remote_in,
	input wire logic rl_lockout_in,
	// Data path
	input wire logic [7:0] data_in_byte_in,
	input wire logic byte_received_in,
	input wire logic talker_ready_in,
	output logic [7:0] data_out_byte_out,
	output logic data_out_write_out,
	// Source settling delay
	input wire logic settle_start_in,
	output logic settle_done_out,
	// Function outputs
	output logic listener_active_out,
	output logic talker_active_out,
	output logic remote_poll_config_out,
	output logic dma_request_pin_n_out
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic short_settle_delay;
		logic remote_poll_config;
		logic dma_request_enable;
		logic dual_address;
		logic listen_disable;
		logic talk_disable;
		logic [4:0] primary_address;
		logic listen_primary_seen;
		logic talk_primary_seen;
		logic listener;
		logic talker;
		logic ulpa;
		logic dma_request;
		logic [7:0] rdata;
		logic [7:0] data_out;
		logic data_out_wr;
		gas_pkg::gas_settle_t settle_state;
		logic [gas_pkg::SETTLE_W-1:0] settle_cnt;
		logic settle_done;
	} gas_state_t;

	gas_state_t state_reg;
	gas_state_t state_next;
	logic [1:0] pins_sync;
	logic atn_asserted;
	logic ifc_asserted;
	logic pcg;
	logic mla;
	logic mta;
	logic ota;
	logic unl;
	logic [7:0] status;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	gas_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.d_in({atn_n_in, ifc_n_in}),
		.q_out(pins_sync)
	);

	assign atn_asserted = ~pins_sync[1];
	assign ifc_asserted = ~pins_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// Command decode; dual mode ignores the address low bit
	function automatic logic addr_match(input logic [6:0] code, input logic [6:0] base,
		input logic [4:0] prim, input logic dual);
		logic [6:0] own;
		own = base + {2'h0, prim};
		addr_match = dual ? (code[6:1] == own[6:1]) : (code == own);
	endfunction

	assign pcg = cmd_byte_in[6:5] != gas_pkg::GROUP_SECONDARY;
	assign mla = addr_match(cmd_byte_in[6:0], gas_pkg::LISTEN_BASE, state_reg.primary_address,
		state_reg.dual_address);
	assign mta = addr_match(cmd_byte_in[6:0], gas_pkg::TALK_BASE, state_reg.primary_address,
		state_reg.dual_address);
	assign ota = (cmd_byte_in[6:5] == gas_pkg::GROUP_TALK) && !mta;
	assign unl = cmd_byte_in[6:0] == gas_pkg::CMD_UNLISTEN;

	always_comb begin
		status = gas_pkg::RESET_BYTE;
		status[gas_pkg::ST_LOCKOUT_BIT] = rl_lockout_in;
		status[gas_pkg::ST_REMOTE_BIT] = rl_remote_in;
		status[gas_pkg::ST_ATN_BIT] = atn_asserted;
		status[gas_pkg::ST_LISTEN_SEEN_BIT] = state_reg.listen_primary_seen;
		status[gas_pkg::ST_TPAS_BIT] = state_reg.talk_primary_seen;
		status[gas_pkg::ST_LA_BIT] = state_reg.listener;
		status[gas_pkg::ST_TA_BIT] = state_reg.talker;
		status[gas_pkg::ST_ULPA_BIT] = state_reg.ulpa;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.data_out_wr = 1'b0;
		state_next.settle_done = 1'b0;
		state_next.rdata = gas_pkg::RESET_BYTE;
		// Host writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				gas_pkg::OFS_ACCESSORY: begin
					// Other selector codes belong to sibling accessory registers; bit 1 is ignored
					if (reg_wdata_in[gas_pkg::ACC_SEL_MSB:gas_pkg::ACC_SEL_LSB] == gas_pkg::ACC_SEL_POLL_DMA) begin
						state_next.short_settle_delay = reg_wdata_in[gas_pkg::ACC_SHORT_DELAY_BIT];
						state_next.remote_poll_config = reg_wdata_in[gas_pkg::ACC_POLL_CFG_BIT];
						state_next.dma_request_enable = reg_wdata_in[gas_pkg::ACC_DMA_EN_BIT];
					end
				end
				gas_pkg::OFS_ADDRESS: begin
					// All-ones address is accepted as written; software must avoid it
					state_next.dual_address = reg_wdata_in[gas_pkg::PRIM_DUAL_BIT];
					state_next.listen_disable = reg_wdata_in[gas_pkg::PRIM_NO_LISTEN_BIT];
					state_next.talk_disable = reg_wdata_in[gas_pkg::PRIM_NO_TALK_BIT];
					state_next.primary_address = reg_wdata_in[gas_pkg::PRIM_FIELD_MSB:0];
				end
				gas_pkg::OFS_DATA: begin
					state_next.data_out = reg_wdata_in;
					state_next.data_out_wr = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// Host reads, answered in the next cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				gas_pkg::OFS_ADDRESS: state_next.rdata = status;
				gas_pkg::OFS_DATA: state_next.rdata = data_in_byte_in;
				default: state_next.rdata = gas_pkg::RESET_BYTE;
			endcase
		end
		// Channel reset first, so an address received in the same cycle wins
		if (chan_reset_in) begin
			state_next.ulpa = 1'b0;
		end
		// Addressing
		if (cmd_accept_in && pcg) begin
			state_next.listen_primary_seen = mla;
			state_next.talk_primary_seen = mta;
			if (mla || mta) begin
				state_next.ulpa = cmd_byte_in[0];
			end
			if (mla) begin
				state_next.listener = 1'b1;
				state_next.talker = 1'b0;
			end else if (mta) begin
				state_next.talker = 1'b1;
				state_next.listener = 1'b0;
			end else begin
				if (unl) begin
					state_next.listener = 1'b0;
				end
				if (ota) begin
					state_next.talker = 1'b0;
				end
			end
		end
		if (listen_only_in) begin
			state_next.listener = 1'b1;
			state_next.talker = 1'b0;
		end
		if (talk_only_in) begin
			state_next.talker = 1'b1;
			state_next.listener = 1'b0;
		end
		if (ifc_asserted) begin
			state_next.listener = 1'b0;
			state_next.talker = 1'b0;
		end
		// Disables override any addressing seen in the same cycle
		if (state_next.listen_disable) begin
			state_next.listener = 1'b0;
		end
		if (state_next.talk_disable) begin
			state_next.talker = 1'b0;
		end
		// DMA request: a new event wins over a clearing data access
		if (reg_wr_in && reg_addr_in == gas_pkg::OFS_DATA) begin
			state_next.dma_request = 1'b0;
		end
		if (reg_rd_in && reg_addr_in == gas_pkg::OFS_DATA) begin
			state_next.dma_request = 1'b0;
		end
		if (state_reg.dma_request_enable && (byte_received_in || talker_ready_in)) begin
			state_next.dma_request = 1'b1;
		end
		// Settling delay; the length is chosen at start so a mid-run change does not cut it
		case (state_reg.settle_state)
			gas_pkg::GAS_SETTLE_IDLE: begin
				if (settle_start_in) begin
					state_next.settle_state = gas_pkg::GAS_SETTLE_RUN;
					state_next.settle_cnt = state_reg.short_settle_delay ?
						gas_pkg::SETTLE_W'(gas_pkg::SHORT_SETTLE_CYC - 1) :
						gas_pkg::SETTLE_W'(gas_pkg::NORMAL_SETTLE_CYC - 1);
				end
			end
			gas_pkg::GAS_SETTLE_RUN: begin
				if (state_reg.settle_cnt == '0) begin
					state_next.settle_state = gas_pkg::GAS_SETTLE_IDLE;
					state_next.settle_done = 1'b1;
				end else begin
					state_next.settle_cnt = state_reg.settle_cnt - 1'b1;
				end
			end
			default: state_next.settle_state = gas_pkg::GAS_SETTLE_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= '0;
			state_reg.settle_state <= gas_pkg::GAS_SETTLE_IDLE;
		end else if (ce_in) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign reg_rdata_out = state_reg.rdata;
	assign data_out_byte_out = state_reg.data_out;
	assign data_out_write_out = state_reg.data_out_wr;
	assign settle_done_out = state_reg.settle_done;
	assign listener_active_out = state_reg.listener;
	assign talker_active_out = state_reg.talker;
	assign remote_poll_config_out = state_reg.remote_poll_config;
	assign dma_request_pin_n_out = ~state_reg.dma_request;
endmodule

/* File: src/gas_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module gas_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else if (ce_in) begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;
endmodule

/* File: testbench/gas_ctl_model.sv */
// Behavioural controller in charge: attention, commands, interface clear
`timescale 1ns/10ps
module gas_ctl_model (
	// Clock
	input wire logic clk_in,
	// Bus side
	output logic atn_n_out = 1'b1,
	output logic ifc_n_out = 1'b1,
	output logic cmd_accept_out = 1'b0,
	output logic [7:0] cmd_byte_out = 8'h00
);
	task automatic set_atn(input logic n);
		@(posedge clk_in);
		atn_n_out <= n;
	endtask
	task automatic send_cmd(input logic [7:0] c);
		set_atn(1'b0);
		@(posedge clk_in);
		cmd_accept_out <= 1'b1;
		cmd_byte_out <= c;
		@(posedge clk_in);
		cmd_accept_out <= 1'b0;
		// Released lines must not keep the last byte
		cmd_byte_out <= ~c;
		set_atn(1'b1);
		repeat (3) @(posedge clk_in);
	endtask
	task automatic pulse_ifc;
		@(posedge clk_in);
		ifc_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		ifc_n_out <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask
endmodule

/* File: testbench/gas_regs_asserts.sv */
// Port checker of the address and status register bank
`timescale 1ns/10ps
module gas_regs_chk (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Host port
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Bus side
	input wire logic atn_n_in,
	input wire logic cmd_accept_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic rl_remote_in,
	input wire logic rl_lockout_in,
	input wire logic byte_received_in,
	input wire logic talker_ready_in,
	// Function outputs
	input wire logic listener_active_out,
	input wire logic talker_active_out,
	input wire logic dma_request_pin_n_out
);
	logic [7:0] prim_q;
	logic dma_q;
	// Shadows of the write-only settings, since they cannot be read back
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prim_q <= 8'h00;
			dma_q <= 1'b0;
		end else if (reg_wr_in && ce_in) begin
			if (reg_addr_in == 2'h1)
				prim_q <= reg_wdata_in;
			if (reg_addr_in == 2'h0 && reg_wdata_in[7:4] == 4'he)
				dma_q <= reg_wdata_in[0];
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////
	property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rl; reg_rd_in && reg_addr_in == 2'h1 |=> reg_rdata_out[7:6] == {$past(rl_remote_in), $past(rl_lockout_in)}; endproperty
	a_rl: assert property (p_rl) else $error("remote lockout status wrong");
	property p_atn; reg_rd_in && reg_addr_in == 2'h1 && atn_n_in == $past(atn_n_in) && atn_n_in == $past(atn_n_in, 3)
		&& atn_n_in == $past(atn_n_in, 2) |=> reg_rdata_out[5] == !$past(atn_n_in); endproperty
	a_atn: assert property (p_atn) else $error("attention status wrong");
	property p_lnoff; prim_q[6] && $past(prim_q[6]) |-> !listener_active_out; endproperty
	a_lnoff: assert property (p_lnoff) else $error("listener active while disabled");
	property p_tkoff; prim_q[5] && $past(prim_q[5]) |-> !talker_active_out; endproperty
	a_tkoff: assert property (p_tkoff) else $error("talker active while disabled");
	property p_mla; cmd_accept_in && !prim_q[6] && cmd_byte_in[6:5] == 2'h1 && (cmd_byte_in[4:0] == prim_q[4:0]
		|| prim_q[7] && cmd_byte_in[4:1] == prim_q[4:1]) |=> listener_active_out && !talker_active_out; endproperty
	a_mla: assert property (p_mla) else $error("own listen address missed");
	property p_mta; cmd_accept_in && !prim_q[5] && cmd_byte_in[6:5] == 2'h2 && (cmd_byte_in[4:0] == prim_q[4:0]
		|| prim_q[7] && cmd_byte_in[4:1] == prim_q[4:1]) |=> talker_active_out && !listener_active_out; endproperty
	a_mta: assert property (p_mta) else $error("own talk address missed");
	// A frozen clock enable swallows the source pulse
	property p_dma_set; ce_in && dma_q && (byte_received_in || talker_ready_in) |=> !dma_request_pin_n_out;
		endproperty
	a_dma_set: assert property (p_dma_set) else $error("dma request not raised");
	property p_dma_clr; !dma_request_pin_n_out && (reg_rd_in || reg_wr_in) && reg_addr_in == 2'h2
		&& !byte_received_in && !talker_ready_in |=> dma_request_pin_n_out; endproperty
	a_dma_clr: assert property (p_dma_clr) else $error("dma request not cleared");
endmodule
bind gas_regs gas_regs_chk chk (.clk_in, .sys_rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .atn_n_in, .cmd_accept_in, .cmd_byte_in, .rl_remote_in, .rl_lockout_in, .byte_received_in,
	.talker_ready_in, .listener_active_out, .talker_active_out, .dma_request_pin_n_out);

/* File: testbench/tb_top.sv */
// Self-checking bench of the address and status register bank
`timescale 1ns/10ps
module tb_top;
	logic clk_in = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic remote = 1'b0;
	logic lockout = 1'b0;
	logic ce = 1'b1;
	logic [7:0] din = 8'h5a;
	logic [5:0] pls = 6'h00;
	logic [7:0] rdata, dout, cmd, v;
	logic dwr, sdone, lact, tact, ppc, dreq_n, atn_n, ifc_n, cacc;
	int fail_count = 0;
	int check_count = 0;
	int n;
	always #20 clk_in = ~clk_in;
	gas_ctl_model ctl (.clk_in(clk_in), .atn_n_out(atn_n), .ifc_n_out(ifc_n), .cmd_accept_out(cacc),
		.cmd_byte_out(cmd));
	gas_regs uut (.clk_in(clk_in), .sys_rst_in(rst), .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .atn_n_in(atn_n), .ifc_n_in(ifc_n),
		.cmd_accept_in(cacc), .cmd_byte_in(cmd), .listen_only_in(pls[0]), .talk_only_in(pls[1]),
		.chan_reset_in(pls[2]), .rl_remote_in(remote), .rl_lockout_in(lockout), .data_in_byte_in(din),
		.byte_received_in(pls[3]), .talker_ready_in(pls[4]), .data_out_byte_out(dout), .data_out_write_out(dwr),
		.settle_start_in(pls[5]), .settle_done_out(sdone), .listener_active_out(lact), .talker_active_out(tact),
		.remote_poll_config_out(ppc), .dma_request_pin_n_out(dreq_n));
	////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pulse(input int i);
		@(posedge clk_in);
		pls[i] <= 1'b1;
		@(posedge clk_in);
		pls <= 6'h00;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////
	// Generous bound, the sequence needs well under a tenth of it
	initial begin
		#400000;
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge clk_in);
		rst <= 1'b0;
		rd_reg(2'h1);
		check("status reset", v, 8'h00);
		rd_reg(2'h3);
		check("unmapped", v, 8'h00);
		// Address 5 avoids the all-ones value
		wr_reg(2'h1, 8'h05);
		ctl.send_cmd(8'h25);
		rd_reg(2'h1);
		check("own listen", v, 8'h15);
		ctl.send_cmd(8'h45);
		rd_reg(2'h1);
		check("own talk", v, 8'h0b);
		ctl.send_cmd(8'h26);
		rd_reg(2'h1);
		check("other listen", v, 8'h03);
		wr_reg(2'h1, 8'h84);
		ctl.send_cmd(8'h44);
		ctl.send_cmd(8'h25);
		rd_reg(2'h1);
		check("dual listen", v, 8'h15);
		pulse(2);
		rd_reg(2'h1);
		check("chan reset", v, 8'h14);
		ctl.pulse_ifc();
		check("ifc", {7'h00, lact}, 8'h00);
		wr_reg(2'h1, 8'h44);
		ctl.send_cmd(8'h24);
		pulse(0);
		#1 check("no listen", {7'h00, lact}, 8'h00);
		wr_reg(2'h1, 8'h24);
		ctl.send_cmd(8'h44);
		pulse(1);
		#1 check("no talk", {7'h00, tact}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			remote <= i[0];
			lockout <= i[1];
			ctl.set_atn(i[1]);
			repeat (3) @(posedge clk_in);
			rd_reg(2'h1);
			check("rl atn", {5'h00, v[7:5]}, {5'h00, i[0], i[1], ~i[1]});
		end
		wr_reg(2'h0, 8'he5);
		#1 check("poll cfg", {7'h00, ppc}, 8'h01);
		wr_reg(2'h0, 8'hc0);
		pulse(3);
		#1 check("dma rx", {7'h00, dreq_n}, 8'h00);
		din <= 8'hc3;
		rd_reg(2'h2);
		check("data in", v, 8'hc3);
		check("dma rd clr", {7'h00, dreq_n}, 8'h01);
		pulse(4);
		#1 check("dma tx", {7'h00, dreq_n}, 8'h00);
		wr_reg(2'h2, 8'ha3);
		#1 check("data out", dout, 8'ha3);
		check("dma wr clr", {6'h00, dreq_n, dwr}, 8'h03);
		// Clock enable low must freeze the request flag
		ce <= 1'b0;
		pulse(3);
		ce <= 1'b1;
		#1 check("ce freeze", {7'h00, dreq_n}, 8'h01);
		for (int k = 0; k < 2; k++) begin
			wr_reg(2'h0, k ? 8'he0 : 8'he8);
			pulse(5);
			n = 0;
			while (sdone !== 1'b1 && n < 100) begin
				@(posedge clk_in);
				#1 n++;
			end
			check("settle", {7'h00, n >= (k ? 49 : 8) && n <= (k ? 51 : 10)}, 8'h01);
		end
		give_verdict();
	end
endmodule
